// *** inc/vic_pkg.sv ***
package vic_pkg;
  // Vector space
  localparam int NUM_TRAP = 8;
  localparam int NUM_SRC = 64;
  localparam int NUM_ARB = NUM_TRAP + NUM_SRC;
  localparam int NUM_VEC = 126;
  localparam int NUM_IPR = 16;
  // Five traps and 61 peripheral sources are wired
  localparam logic [7:0] TRAP_IMPL_MASK = 8'h1f;
  localparam logic [63:0] SRC_IMPL_MASK = 64'h3fff_dfff_ffff_ffff;
  // Levels
  localparam logic [3:0] LVL_OFF = 4'h0;
  localparam logic [3:0] TRAP_LEVEL = 4'h8;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  // Program memory locations
  localparam logic [23:0] RESET_ADDR = 24'h000000;
  localparam logic [23:0] PRI_BASE = 24'h000004;
  localparam logic [23:0] ALT_BASE = PRI_BASE + 24'(NUM_VEC);
  // Fixed latencies in cycles
  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] RET_CYCLES = 3'h3;
  // Register map
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_IEN0 = 5'h00;
  localparam logic [4:0] ADDR_IEN_TWO = 5'h02;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h04;
  localparam logic [4:0] ADDR_STS = 5'h05;
  localparam logic [4:0] ADDR_SCLR = 5'h06;
  localparam logic [4:0] ADDR_SIEN = 5'h07;
  localparam logic [4:0] ADDR_VIDX = 5'h08;
  localparam logic [4:0] ADDR_VLO = 5'h09;
  localparam logic [4:0] ADDR_VHI = 5'h0a;
  localparam logic [4:0] ADDR_ACTIVE = 5'h0b;
  localparam logic [4:0] ADDR_IPR0 = 5'h10;
  localparam int ALT_SEL_BIT = 15;
  localparam int VIDX_SEL_BIT = 15;
  // Status event bits
  localparam int STS_W = 3;
  localparam int STS_IRQ = 0;
  localparam int STS_TRAP = 1;
  localparam int STS_RET = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENTRY = 2'b01,
    ST_RETURN = 2'b10
  } vic_state_t;

  typedef struct packed {
    logic valid;
    logic [6:0] vector;
    logic [3:0] level;
    logic [23:0] handler;
    logic [23:0] loc;
  } vic_disp_t;
endpackage

// *** src/vic_top.sv ***
`timescale 1ns/10ps
// Overview of operation
// - All peripheral requests merge into one request line to the core.
// - Seven software priority levels per source; level zero disables.
// - Up to eight traps handled besides peripheral interrupts.
// - Primary vector table starts at word address 000004h.
// - Table holds 126 entries: eight traps then up to 118 sources.
// - Each source owns one distinct vector entry.
// - Entries are 24-bit handler addresses handed to the core.
// - On ties the lower vector number wins; vector 0 highest.
// - Order within one level is fixed, never rotating.
// - 61 peripheral interrupts and 5 traps are implemented.
// - Alternate table follows the primary with identical layout.
// - Alternate select bit 15 of control two picks alternate vectors.
// - Entry and return latencies are fixed cycle counts.
// - Reset bypasses arbitration, clears registers but loads priorities with 4, hands out address zero.
// - Enable group two gates its sources; bit 13 zero; reset zero.
module vic_top (
  input wire logic sys_clk_in, // Core clock
  input wire logic resetn_in, // Async reset, active low
  input wire logic [vic_pkg::ADDR_W-1:0] addr_in, // Register address
  input wire logic [15:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [15:0] rdata_out, // Read data, cycle after strobe
  input wire logic [vic_pkg::NUM_SRC-1:0] irq_in, // Peripheral request levels
  input wire logic [vic_pkg::NUM_TRAP-1:0] trap_in, // Trap request levels
  input wire logic [3:0] cpu_ipl_in, // Core current priority
  input wire logic ack_in, // Core accepts request
  input wire logic ret_in, // Core returns from handler
  output logic irq_req_out, // Combined request to core
  output logic [3:0] req_level_out, // Level of pending winner
  output vic_pkg::vic_disp_t disp_out, // Dispatch to core
  output logic ret_done_out, // Return sequence finished
  output logic ctrl_irq_out // Status interrupt
);
  import vic_pkg::*;

  vic_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [NUM_SRC-1:0] en_q;
  logic [2:0] prio_q [NUM_SRC];
  logic alt_q;
  logic [STS_W-1:0] sts_q, sie_q;
  logic vsel_q;
  logic [6:0] vidx_q;
  logic [7:0] vhi_q;
  logic [6:0] win_vec_q;
  logic [3:0] win_lvl_q;
  logic win_alt_q;
  vic_disp_t disp_q;
  logic ret_done_q;
  logic [15:0] rdata_q;
  logic [23:0] pri_tab [NUM_VEC];
  logic [23:0] alt_tab [NUM_VEC];

  // Register decode
  wire wr_ien = wr_in && (addr_in[4:2] == ADDR_IEN0[4:2]);
  wire wr_ctrl = wr_in && (addr_in == ADDR_CTRL_TWO);
  wire wr_sclr = wr_in && (addr_in == ADDR_SCLR);
  wire wr_sien = wr_in && (addr_in == ADDR_SIEN);
  wire wr_vidx = wr_in && (addr_in == ADDR_VIDX);
  wire wr_vlo = wr_in && (addr_in == ADDR_VLO);
  wire wr_vhi = wr_in && (addr_in == ADDR_VHI);
  wire wr_ipr = wr_in && (addr_in[4] == ADDR_IPR0[4]);
  wire [1:0] ien_grp = addr_in[1:0];
  wire [3:0] ipr_reg = addr_in[3:0];
  wire vidx_ok = (vidx_q < 7'(NUM_VEC));

  // Per-vector effective level
  logic [3:0] lvl [NUM_ARB];
  genvar g;
  generate
    for (g = 0; g < NUM_ARB; g++) begin : g_lvl
      if (g < NUM_TRAP) begin : g_trap
        // Traps are nonmaskable and sit above every user level
        assign lvl[g] = (trap_in[g] && TRAP_IMPL_MASK[g]) ? TRAP_LEVEL : LVL_OFF;
      end else begin : g_src
        localparam int S = g - NUM_TRAP;
        assign lvl[g] = (irq_in[S] && en_q[S] && SRC_IMPL_MASK[S]) ?
                        {1'b0, prio_q[S]} : LVL_OFF;
      end
    end
  endgenerate

  // Priority registers, four fields per word
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_prio
      wire hit = wr_ipr && (ipr_reg == 4'(g / 4));
      always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          prio_q[g] <= PRIO_RESET;
        end else if (hit) begin
          prio_q[g] <= wdata_in[(g % 4) * 4 +: 3];
        end
      end
    end
  endgenerate

  logic [15:0] ipr_word [NUM_IPR];
  generate
    for (g = 0; g < NUM_IPR; g++) begin : g_iprw
      assign ipr_word[g] = {1'b0, prio_q[4 * g + 3], 1'b0, prio_q[4 * g + 2],
                            1'b0, prio_q[4 * g + 1], 1'b0, prio_q[4 * g]};
    end
  endgenerate

  // Arbitration: highest level, then lowest vector
  logic [6:0] best_vec;
  logic [3:0] best_lvl;
  always_comb begin
    best_vec = 7'h00;
    best_lvl = LVL_OFF;
    for (int i = NUM_ARB - 1; i >= 0; i--) begin
      // Descending scan with >= lets the lower vector take a tie
      if ((lvl[i] != LVL_OFF) && (lvl[i] >= best_lvl)) begin
        best_vec = 7'(i);
        best_lvl = lvl[i];
      end
    end
  end

  wire pend = (best_lvl != LVL_OFF) && (best_lvl > cpu_ipl_in);
  assign irq_req_out = pend && (state_q == ST_IDLE);
  assign req_level_out = best_lvl;

  // Table lookups
  wire [23:0] disp_entry = win_alt_q ? alt_tab[win_vec_q] : pri_tab[win_vec_q];
  wire [23:0] disp_base = win_alt_q ? ALT_BASE : PRI_BASE;
  wire [23:0] disp_loc = disp_base + {17'h00000, win_vec_q};
  wire [23:0] bus_entry = !vidx_ok ? 24'h000000 :
                          vsel_q ? alt_tab[vidx_q] : pri_tab[vidx_q];

  // Sequencer
  wire cnt_done = (cnt_q == 3'h0);
  wire entry_done = (state_q == ST_ENTRY) && cnt_done;
  wire ret_done = (state_q == ST_RETURN) && cnt_done;
  wire take = (state_q == ST_IDLE) && ack_in && pend;
  wire start_ret = (state_q == ST_IDLE) && !take && ret_in;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_ENTRY;
          cnt_d = ENTRY_CYCLES - 3'h1;
        end else if (start_ret) begin
          state_d = ST_RETURN;
          cnt_d = RET_CYCLES - 3'h1;
        end
      end
      ST_ENTRY: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      ST_RETURN: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Winner is frozen at acceptance; alternate select sampled too
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      win_vec_q <= 7'h00;
      win_lvl_q <= LVL_OFF;
      win_alt_q <= 1'b0;
    end else if (take) begin
      win_vec_q <= best_vec;
      win_lvl_q <= best_lvl;
      win_alt_q <= alt_q;
    end
  end

  // Dispatch record; reset hands out the reset address
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      disp_q <= '{valid: 1'b0, vector: 7'h00, level: LVL_OFF,
                  handler: RESET_ADDR, loc: RESET_ADDR};
    end else if (entry_done) begin
      disp_q <= '{valid: 1'b1, vector: win_vec_q, level: win_lvl_q,
                  handler: disp_entry, loc: disp_loc};
    end else begin
      disp_q.valid <= 1'b0;
    end
  end
  assign disp_out = disp_q;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ret_done_q <= 1'b0;
    end else begin
      ret_done_q <= ret_done;
    end
  end
  assign ret_done_out = ret_done_q;

  // Control registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_q <= '0;
    end else if (wr_ien) begin
      en_q[ien_grp * 16 +: 16] <= wdata_in & SRC_IMPL_MASK[ien_grp * 16 +: 16];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alt_q <= 1'b0;
    end else if (wr_ctrl) begin
      alt_q <= wdata_in[ALT_SEL_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vsel_q <= 1'b0;
      vidx_q <= 7'h00;
    end else if (wr_vidx) begin
      vsel_q <= wdata_in[VIDX_SEL_BIT];
      vidx_q <= wdata_in[6:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vhi_q <= 8'h00;
    end else if (wr_vhi) begin
      vhi_q <= wdata_in[7:0];
    end
  end

  // Vector tables; a low-half write commits the staged entry
  always_ff @(posedge sys_clk_in) begin
    if (wr_vlo && vidx_ok) begin
      if (vsel_q) begin
        alt_tab[vidx_q] <= {vhi_q, wdata_in};
      end else begin
        pri_tab[vidx_q] <= {vhi_q, wdata_in};
      end
    end
  end

  // Status events; a set wins over a clear in the same cycle
  wire [STS_W-1:0] ev;
  assign ev[STS_IRQ] = entry_done && (win_vec_q >= 7'(NUM_TRAP));
  assign ev[STS_TRAP] = entry_done && (win_vec_q < 7'(NUM_TRAP));
  assign ev[STS_RET] = ret_done;
  wire [STS_W-1:0] sclr = wr_sclr ? wdata_in[STS_W-1:0] : '0;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sts_q <= '0;
      sie_q <= '0;
    end else begin
      sts_q <= (sts_q & ~sclr) | ev;
      if (wr_sien) begin
        sie_q <= wdata_in[STS_W-1:0];
      end
    end
  end
  assign ctrl_irq_out = |(sts_q & sie_q);

  // Read mux
  wire [15:0] active_word = {1'b0, state_q, 1'b0, win_lvl_q, win_alt_q, win_vec_q};
  logic [15:0] rmux;
  always_comb begin
    rmux = 16'h0000;
    if (addr_in[4] == ADDR_IPR0[4]) begin
      rmux = ipr_word[ipr_reg];
    end else if (addr_in[4:2] == ADDR_IEN0[4:2]) begin
      rmux = en_q[ien_grp * 16 +: 16];
    end else begin
      case (addr_in)
        ADDR_CTRL_TWO: rmux = {alt_q, 15'h0000};
        ADDR_STS: rmux = {13'h0000, sts_q};
        ADDR_SIEN: rmux = {13'h0000, sie_q};
        ADDR_VIDX: rmux = {vsel_q, 8'h00, vidx_q};
        ADDR_VLO: rmux = bus_entry[15:0];
        ADDR_VHI: rmux = {8'h00, bus_entry[23:16]};
        ADDR_ACTIVE: rmux = active_word;
        default: rmux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_in ? rmux : 16'h0000;
    end
  end
  assign rdata_out = rdata_q;
endmodule // vic_top

// *** sim/vic_chk_sva.sv ***
`timescale 1ns/10ps
module vic_chk (
  input wire logic sys_clk_in, // Clock
  input wire logic resetn_in, // Reset
  input wire logic [vic_pkg::ADDR_W-1:0] addr_in, // Addr
  input wire logic [15:0] wdata_in, // Wdata
  input wire logic wr_in, // Write
  input wire logic rd_in, // Read
  input wire logic [15:0] rdata_out, // Rdata
  input wire logic [vic_pkg::NUM_SRC-1:0] irq_in, // Sources
  input wire logic [vic_pkg::NUM_TRAP-1:0] trap_in, // Traps
  input wire logic [3:0] cpu_ipl_in, // Core level
  input wire logic ack_in, // Accept
  input wire logic ret_in, // Return
  input wire logic irq_req_out, // Request
  input wire logic [3:0] req_level_out, // Level
  input wire vic_pkg::vic_disp_t disp_out, // Dispatch
  input wire logic ret_done_out, // Ret done
  input wire logic ctrl_irq_out // Status irq
);
  import vic_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_take;
    ack_in && irq_req_out;
  endsequence
  sequence s_quiet;
    !irq_req_out [*3];
  endsequence
  chk_entry_lat: assert property (s_take |-> ##5 disp_out.valid)
    else $error("entry latency off");
  chk_valid_cause: assert property (disp_out.valid |-> $past(ack_in, 5) && $past(irq_req_out, 5))
    else $error("dispatch without accept");
  chk_busy_quiet: assert property (s_take |=> s_quiet)
    else $error("request while busy");
  chk_ret_lat: assert property (ret_done_out |-> $past(ret_in, 4))
    else $error("return latency off");
  chk_ret_pulse: assert property (ret_done_out |=> !ret_done_out)
    else $error("return done too long");
  chk_loc_base: assert property (disp_out.valid |-> disp_out.loc == PRI_BASE + 24'(disp_out.vector) ||
    disp_out.loc == ALT_BASE + 24'(disp_out.vector))
    else $error("entry location off");
  chk_trap_level: assert property (disp_out.valid && disp_out.vector < 7'h08 |-> disp_out.level == TRAP_LEVEL)
    else $error("trap level off");
  chk_req_above: assert property (irq_req_out |-> req_level_out > cpu_ipl_in)
    else $error("request not above core level");
endmodule // vic_chk

// *** sim/vic_core_model.sv ***
`timescale 1ns/10ps
module vic_core_model (
  input wire logic sys_clk_in, // Clock
  input wire logic resetn_in, // Reset
  input wire logic go_in, // Allow accepts
  input wire logic irq_req_in, // Request
  input wire vic_pkg::vic_disp_t disp_in, // Dispatch
  input wire logic ret_done_in, // Return done
  output logic ack_out, // Accept pulse
  output logic ret_out // Return pulse
);
  import vic_pkg::*;
  logic pend_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      ack_out <= go_in && irq_req_in && !ack_out && !pend_q;
      // Return at once after entry, no accept until finished
      ret_out <= disp_in.valid;
      if (ack_out && irq_req_in) begin
        pend_q <= 1'b1;
      end else if (ret_done_in) begin
        pend_q <= 1'b0;
      end
    end
  end
endmodule // vic_core_model

// *** sim/vic_top_tb.sv ***
`timescale 1ns/10ps
module vic_top_tb;
  import vic_pkg::*;
  typedef struct packed {logic [63:0] irq; logic [7:0] trap; logic alt; logic [6:0] vec;} vic_row_t;
  vic_row_t rows [5] = '{'{64'h1, 8'h0, 1'b0, 7'h08}, '{64'h3, 8'h0, 1'b0, 7'h08},
    '{64'h2_0000_0000, 8'h0, 1'b1, 7'h29}, '{64'h1, 8'h04, 1'b0, 7'h02}, '{64'h8000_0000_0000, 8'h0, 1'b0, 7'h37}};
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] addr_in = 5'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [63:0] irq_in = 64'h0;
  logic [7:0] trap_in = 8'h00;
  logic [3:0] cpu_ipl_in = 4'h0;
  logic go = 1'b0;
  logic ack_in, ret_in, irq_req_out, ret_done_out, ctrl_irq_out;
  logic [15:0] rdata_out;
  logic [3:0] req_level_out;
  vic_disp_t disp_out;
  logic [23:0] h;
  int num_errors = 0;
  int compares = 0;
  vic_top DUT (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_in, .trap_in,
    .cpu_ipl_in, .ack_in, .ret_in, .irq_req_out, .req_level_out, .disp_out, .ret_done_out, .ctrl_irq_out);
  vic_core_model u_core (.sys_clk_in, .resetn_in, .go_in(go), .irq_req_in(irq_req_out), .disp_in(disp_out),
    .ret_done_in(ret_done_out), .ack_out(ack_in), .ret_out(ret_in));
  always #20 sys_clk_in = ~sys_clk_in;
  task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_val(n, {23'h0, e}, {23'h0, g});
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_in) begin
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
    end
    @(posedge sys_clk_in) wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk_in) begin
      addr_in <= a;
      rd_in <= 1'b1;
    end
    @(posedge sys_clk_in) rd_in <= 1'b0;
    @(negedge sys_clk_in) chk_val("rdata", {8'h0, e}, {8'h0, rdata_out});
  endtask
  task automatic end_of_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd(ADDR_IEN_TWO, 16'h0000);
    rd(ADDR_CTRL_TWO, 16'h0000);
    rd(5'h0c, 16'h0000);
    for (int k = 0; k < 4; k++) wr(ADDR_IEN0 + 5'(k), 16'hffff);
    rd(ADDR_IEN_TWO, 16'hdfff);
    foreach (rows[k]) begin
      h = {rows[k].alt ? 8'h2a : 8'h1a, 9'h000, rows[k].vec};
      wr(ADDR_CTRL_TWO, {rows[k].alt, 15'h0});
      wr(ADDR_VIDX, {rows[k].alt, 8'h00, rows[k].vec});
      wr(ADDR_VHI, {8'h00, h[23:16]});
      wr(ADDR_VLO, h[15:0]);
      @(posedge sys_clk_in) begin
        irq_in <= rows[k].irq;
        trap_in <= rows[k].trap;
        go <= 1'b1;
      end
      for (int i = 0; i < 20 && disp_out.valid !== 1'b1; i++) @(negedge sys_clk_in);
      chk_val("vector", 24'(rows[k].vec), 24'(disp_out.vector));
      chk_val("handler", h, disp_out.handler);
      chk_val("loc", (rows[k].alt ? ALT_BASE : PRI_BASE) + 24'(rows[k].vec), disp_out.loc);
      @(posedge sys_clk_in) begin
        irq_in <= 64'h0;
        trap_in <= 8'h00;
        go <= 1'b0;
      end
      for (int i = 0; i < 20 && ret_done_out !== 1'b1; i++) @(negedge sys_clk_in);
      chk_bit("ret_done", 1'b1, ret_done_out);
    end
    rd(ADDR_STS, 16'h0007);
    wr(ADDR_VIDX, 16'h007e);
    rd(ADDR_VLO, 16'h0000);
    wr(ADDR_SIEN, 16'h0001);
    @(negedge sys_clk_in) chk_bit("ctrl_irq", 1'b1, ctrl_irq_out);
    wr(ADDR_SCLR, 16'h0007);
    @(negedge sys_clk_in) chk_bit("ctrl_irq", 1'b0, ctrl_irq_out);
    wr(ADDR_IPR0, 16'h4443);
    @(posedge sys_clk_in) begin
      cpu_ipl_in <= 4'h3;
      irq_in <= 64'h1;
    end
    @(negedge sys_clk_in) chk_bit("irq_req", 1'b0, irq_req_out);
    chk_val("req_level", 24'h3, 24'(req_level_out));
    @(posedge sys_clk_in) cpu_ipl_in <= 4'h2;
    @(negedge sys_clk_in) chk_bit("irq_req", 1'b1, irq_req_out);
    @(posedge sys_clk_in) begin
      irq_in <= 64'h0;
      resetn_in <= 1'b0;
    end
    @(posedge sys_clk_in) resetn_in <= 1'b1;
    chk_val("handler", RESET_ADDR, disp_out.handler);
    rd(ADDR_IEN_TWO, 16'h0000);
    end_of_test();
  end
endmodule // vic_top_tb
bind vic_top vic_chk u_chk (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_in,
  .trap_in, .cpu_ipl_in, .ack_in, .ret_in, .irq_req_out, .req_level_out, .disp_out, .ret_done_out, .ctrl_irq_out);
